// file: hdl/pcg_top.sv
// Port crossbar routing registers and port A/B general-purpose I/O
`timescale 1ns/1ns

// Notes on behaviour
// - Pull-ups on unless disabled; never on analog or push-pull pins.
// - Matrix enable off turns off routing and every port driver.
// - Timer input route bits give the timer inputs a pin when set.
// - External count input route bit gives that input a pin when set.
// - Module route field routes first N compare outputs, N up to five.
// - Second serial route bit gives transmit and receive pins together.
// - Unassigned digital pins act as general-purpose I/O from latches.
// - Port latches are reachable as whole bytes and as single bits.
// - A latch write holds the pin output data until the next write.
// - Plain port reads return live pin levels, even for routed pins.
// - Read-modify-write accesses read the latch, not the pins.
// - Latch zero drives low; one drives high or floats if open-drain.
// - Reads return zero for analog pins, live level for digital pins.
// - Input-kind zero makes a pin analog: no pull-up, driver or receiver.
// - Drive-mode zero is open-drain, one push-pull; ignored for analog.
// - Pins carrying the two-wire bus lines are always open-drain.
// - Skipped pins are passed over by the decoder.
// - Each enabled signal gets the lowest free unskipped pin, in priority order.
// - Until the matrix is enabled, pins remain undriven port inputs.
// - Pull-up switches off while an open-drain pin drives low.
module pcg_top
  import pcg_pkg::*;
(
  input  wire logic                clock_i,
  input  wire logic                rst_i,
  input  wire logic [7:0]          sfr_addr_i,
  input  wire logic                sfr_wr_i,
  input  wire logic [7:0]          sfr_wdata_i,
  input  wire logic                sfr_bit_wr_i,
  input  wire logic [2:0]          sfr_bit_sel_i,
  input  wire logic                sfr_bit_val_i,
  input  wire logic                sfr_rd_i,
  input  wire logic                sfr_rmw_i,
  output logic      [7:0]          sfr_rdata_o,
  input  wire logic [NUM_PINS-1:0] upstream_claim_i,
  input  wire logic                first_serial_enable_i,
  input  wire logic [NUM_PINS-1:0] twowire_pins_i,
  input  wire logic [NUM_SIG-1:0]  periph_out_i,
  input  wire logic [NUM_SIG-1:0]  periph_oe_i,
  output logic      [NUM_SIG-1:0]  periph_in_o,
  output logic      [NUM_SIG-1:0]  periph_routed_o,
  input  wire logic [NUM_PINS-1:0] pin_i,
  output logic      [NUM_PINS-1:0] pin_o,
  output logic      [NUM_PINS-1:0] pin_oe_n_o,
  output logic      [NUM_PINS-1:0] pullup_en_o,
  output logic      [NUM_PINS-1:0] digital_rx_en_o
);

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [7:0] port_a_output_latch;
  logic [7:0] port_b_output_latch;
  logic [7:0] port_a_output_drive_mode;
  logic [7:0] port_b_output_drive_mode;
  logic [7:0] port_a_route_skip;
  logic [7:0] port_a_input_kind;
  logic [7:0] port_b_input_kind;
  logic [7:0] pin_route_control_second;
  logic       second_serial_route;

  logic [NUM_PINS-1:0] pin_sync;
  logic [NUM_PINS-1:0] latch_all;
  logic [NUM_PINS-1:0] kind_all;
  logic [NUM_PINS-1:0] drive_all;

  logic       pullup_disable;
  logic       matrix_route_enable;
  logic [2:0] counter_array_module_route;

  pcg_route_if rt ();

  // Byte with one bit replaced, used by both bit-addressable latches
  function automatic logic [7:0] set_bit(input logic [7:0] cur, input logic [2:0] sel, input logic val);
    logic [7:0] res;
    res      = cur;
    res[sel] = val;
    return res;
  endfunction : set_bit

  // Analog pins read as zero, digital pins as their live level
  function automatic logic [7:0] pin_view(input logic [7:0] lvl, input logic [7:0] kind);
    return lvl & kind;
  endfunction : pin_view

  function automatic logic wr_hit(input logic [7:0] addr, input logic [7:0] target, input logic wr);
    return wr && (addr == target);
  endfunction : wr_hit

  // ---------------------------------------------------------------
  // Pad input synchroniser
  // ---------------------------------------------------------------
  pcg_sync #(
    .WIDTH (NUM_PINS)
  ) u_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .async_i (pin_i),
    .sync_o  (pin_sync)
  );

  // ---------------------------------------------------------------
  // Port latches
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      port_a_output_latch <= RST_LATCH;
    end else if (wr_hit(sfr_addr_i, ADDR_PORT_A_LATCH, sfr_wr_i)) begin
      port_a_output_latch <= sfr_wdata_i;
    end else if (wr_hit(sfr_addr_i, ADDR_PORT_A_LATCH, sfr_bit_wr_i)) begin
      port_a_output_latch <= set_bit(port_a_output_latch, sfr_bit_sel_i, sfr_bit_val_i);
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      port_b_output_latch <= RST_LATCH;
    end else if (wr_hit(sfr_addr_i, ADDR_PORT_B_LATCH, sfr_wr_i)) begin
      port_b_output_latch <= sfr_wdata_i;
    end else if (wr_hit(sfr_addr_i, ADDR_PORT_B_LATCH, sfr_bit_wr_i)) begin
      port_b_output_latch <= set_bit(port_b_output_latch, sfr_bit_sel_i, sfr_bit_val_i);
    end
  end

  // ---------------------------------------------------------------
  // Pin mode and skip registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      port_a_input_kind        <= RST_KIND;
      port_b_input_kind        <= RST_KIND;
      port_a_output_drive_mode <= RST_DRIVE;
      port_b_output_drive_mode <= RST_DRIVE;
      port_a_route_skip        <= RST_SKIP;
    end else if (sfr_wr_i) begin
      case (sfr_addr_i)
        ADDR_PORT_A_KIND:  port_a_input_kind        <= sfr_wdata_i;
        ADDR_PORT_B_KIND:  port_b_input_kind        <= sfr_wdata_i;
        ADDR_PORT_A_DRIVE: port_a_output_drive_mode <= sfr_wdata_i;
        ADDR_PORT_B_DRIVE: port_b_output_drive_mode <= sfr_wdata_i;
        ADDR_PORT_A_SKIP:  port_a_route_skip        <= sfr_wdata_i;
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Routing registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pin_route_control_second <= RST_ROUTE;
    end else if (wr_hit(sfr_addr_i, ADDR_ROUTE_SECOND, sfr_wr_i)) begin
      pin_route_control_second <= sfr_wdata_i;
    end
  end

  // Only the serial route bit is stored; the upper bits are reserved
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      second_serial_route <= RST_ROUTE[POS_SECOND_SERIAL];
    end else if (wr_hit(sfr_addr_i, ADDR_ROUTE_THIRD, sfr_wr_i)) begin
      second_serial_route <= sfr_wdata_i[POS_SECOND_SERIAL];
    end
  end

  assign pullup_disable             = pin_route_control_second[POS_PULLUP_DISABLE];
  assign matrix_route_enable        = pin_route_control_second[POS_MATRIX_ENABLE];
  assign counter_array_module_route = pin_route_control_second[POS_MODULE_HI:POS_MODULE_LO];

  // ---------------------------------------------------------------
  // Register read path
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sfr_rdata_o <= RD_NONE;
    end else if (sfr_rd_i) begin
      case (sfr_addr_i)
        ADDR_PORT_A_LATCH: sfr_rdata_o <= sfr_rmw_i ? port_a_output_latch
                                                    : pin_view(pin_sync[7:0], port_a_input_kind);
        ADDR_PORT_B_LATCH: sfr_rdata_o <= sfr_rmw_i ? port_b_output_latch
                                                    : pin_view(pin_sync[15:8], port_b_input_kind);
        ADDR_PORT_A_KIND:  sfr_rdata_o <= port_a_input_kind;
        ADDR_PORT_B_KIND:  sfr_rdata_o <= port_b_input_kind;
        ADDR_PORT_A_DRIVE: sfr_rdata_o <= port_a_output_drive_mode;
        ADDR_PORT_B_DRIVE: sfr_rdata_o <= port_b_output_drive_mode;
        ADDR_PORT_A_SKIP:  sfr_rdata_o <= port_a_route_skip;
        ADDR_ROUTE_SECOND: sfr_rdata_o <= pin_route_control_second;
        ADDR_ROUTE_THIRD:  sfr_rdata_o <= {7'h00, second_serial_route};
        default:           sfr_rdata_o <= RD_NONE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Routing requests
  // ---------------------------------------------------------------
  always_comb begin
    rt.sig_en = '0;
    for (int k = SIG_CMP0; k <= SIG_CMP4; k++) begin
      rt.sig_en[k] = (counter_array_module_route <= MODULE_ROUTE_MAX) &&
                     (3'(k) < counter_array_module_route);
    end
    rt.sig_en[SIG_EXTIN] = pin_route_control_second[POS_EXT_INPUT];
    rt.sig_en[SIG_T0]    = pin_route_control_second[POS_TIMER0_ROUTE];
    rt.sig_en[SIG_T1]    = pin_route_control_second[POS_TIMER1_ROUTE];
    rt.sig_en[SIG_TX1]   = second_serial_route;
    rt.sig_en[SIG_RX1]   = second_serial_route;
  end

  // Port B skip bits live in a neighbouring register and read as clear here
  assign rt.skip  = {8'h00, port_a_route_skip};
  assign rt.claim = upstream_claim_i | (first_serial_enable_i ? FIRST_SERIAL_PINS : 16'h0000);

  pcg_decoder u_decoder (
    .rt (rt.decoder)
  );

  // ---------------------------------------------------------------
  // Pin cell control
  // ---------------------------------------------------------------
  assign latch_all = {port_b_output_latch, port_a_output_latch};
  assign kind_all  = {port_b_input_kind, port_a_input_kind};
  assign drive_all = {port_b_output_drive_mode, port_a_output_drive_mode};

  logic [NUM_PINS-1:0] next_pin;
  logic [NUM_PINS-1:0] next_oe_n;
  logic [NUM_PINS-1:0] next_pullup;

  always_comb begin
    logic [SIG_W-1:0] s;
    logic             routed;
    logic             val;
    logic             act;
    logic             push_pull;
    logic             drv_lo;
    logic             drv_hi;
    s           = '0;
    routed      = 1'b0;
    val         = 1'b1;
    act         = 1'b0;
    push_pull   = 1'b0;
    drv_lo      = 1'b0;
    drv_hi      = 1'b0;
    next_pin    = '1;
    next_oe_n   = '1;
    next_pullup = '0;
    for (int p = 0; p < NUM_PINS; p++) begin
      s         = rt.pin_sig[p];
      routed    = matrix_route_enable && rt.pin_assigned[p];
      val       = routed ? periph_out_i[s] : latch_all[p];
      act       = routed ? (periph_oe_i[s] && !SIG_INPUT_ONLY[s]) : 1'b1;
      push_pull = kind_all[p] && drive_all[p] && !twowire_pins_i[p];
      drv_lo    = matrix_route_enable && kind_all[p] && act && !val;
      drv_hi    = matrix_route_enable && kind_all[p] && act && val && push_pull;
      next_pin[p]    = val;
      next_oe_n[p]   = !(drv_lo || drv_hi);
      next_pullup[p] = !pullup_disable && kind_all[p] && !push_pull && !drv_lo;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pin_o           <= '1;
      pin_oe_n_o      <= '1;
      pullup_en_o     <= '1;
      digital_rx_en_o <= '1;
    end else begin
      pin_o           <= next_pin;
      pin_oe_n_o      <= next_oe_n;
      pullup_en_o     <= next_pullup;
      digital_rx_en_o <= kind_all;
    end
  end

  // ---------------------------------------------------------------
  // Peripheral inputs from routed pins
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      periph_in_o     <= '0;
      periph_routed_o <= '0;
    end else begin
      for (int k = 0; k < NUM_SIG; k++) begin
        periph_routed_o[k] <= matrix_route_enable && rt.sig_ok[k];
        periph_in_o[k]     <= matrix_route_enable && rt.sig_ok[k] &&
                              pin_sync[rt.sig_pin[k]] && kind_all[rt.sig_pin[k]];
      end
    end
  end

endmodule : pcg_top

// file: pkg/pcg_pkg.sv
// Shared constants for the port crossbar and general-purpose I/O block
package pcg_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_PINS = 16;
  localparam int NUM_SIG  = 10;
  localparam int PIN_W    = 4;
  localparam int SIG_W    = 4;

  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT_A_LATCH  = 8'h80;
  localparam logic [7:0] ADDR_PORT_B_LATCH  = 8'h90;
  localparam logic [7:0] ADDR_PORT_A_DRIVE  = 8'hA4;
  localparam logic [7:0] ADDR_PORT_B_DRIVE  = 8'hA5;
  localparam logic [7:0] ADDR_PORT_A_SKIP   = 8'hD4;
  localparam logic [7:0] ADDR_ROUTE_SECOND  = 8'hE2;
  localparam logic [7:0] ADDR_ROUTE_THIRD   = 8'hE3;
  localparam logic [7:0] ADDR_PORT_A_KIND   = 8'hF1;
  localparam logic [7:0] ADDR_PORT_B_KIND   = 8'hF2;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_LATCH = 8'hFF;
  localparam logic [7:0] RST_KIND  = 8'hFF;
  localparam logic [7:0] RST_DRIVE = 8'h00;
  localparam logic [7:0] RST_SKIP  = 8'h00;
  localparam logic [7:0] RST_ROUTE = 8'h00;
  localparam logic [7:0] RD_NONE   = 8'h00;

  // ---------------------------------------------------------------
  // Field positions of the second and third routing registers
  // ---------------------------------------------------------------
  localparam int POS_PULLUP_DISABLE = 7;
  localparam int POS_MATRIX_ENABLE  = 6;
  localparam int POS_TIMER1_ROUTE   = 5;
  localparam int POS_TIMER0_ROUTE   = 4;
  localparam int POS_EXT_INPUT      = 3;
  localparam int POS_MODULE_HI      = 2;
  localparam int POS_MODULE_LO      = 0;
  localparam int POS_SECOND_SERIAL  = 0;
  localparam logic [2:0] MODULE_ROUTE_MAX = 3'h5;

  // ---------------------------------------------------------------
  // Routed signals, in decreasing priority
  // ---------------------------------------------------------------
  localparam int SIG_CMP0  = 0;
  localparam int SIG_CMP1  = 1;
  localparam int SIG_CMP2  = 2;
  localparam int SIG_CMP3  = 3;
  localparam int SIG_CMP4  = 4;
  localparam int SIG_EXTIN = 5;
  localparam int SIG_T0    = 6;
  localparam int SIG_T1    = 7;
  localparam int SIG_TX1   = 8;
  localparam int SIG_RX1   = 9;

  // Signals that only drive a peripheral input, never a pin
  localparam logic [9:0] SIG_INPUT_ONLY = 10'h2E0;
  // Pins held by the first serial port
  localparam logic [15:0] FIRST_SERIAL_PINS = 16'h0030;

endpackage : pcg_pkg

// file: pkg/pcg_route_if.sv
// Carrier between the register/pin logic and the priority decoder
`timescale 1ns/1ns
interface pcg_route_if;
  import pcg_pkg::*;

  logic [NUM_PINS-1:0]             skip;
  logic [NUM_PINS-1:0]             claim;
  logic [NUM_SIG-1:0]              sig_en;
  logic [NUM_SIG-1:0]              sig_ok;
  logic [NUM_SIG-1:0][PIN_W-1:0]   sig_pin;
  logic [NUM_PINS-1:0]             pin_assigned;
  logic [NUM_PINS-1:0][SIG_W-1:0]  pin_sig;

  modport decoder (input skip, input claim, input sig_en,
                   output sig_ok, output sig_pin, output pin_assigned, output pin_sig);
  modport owner   (output skip, output claim, output sig_en,
                   input sig_ok, input sig_pin, input pin_assigned, input pin_sig);
endinterface : pcg_route_if

// file: hdl/pcg_sync.sv
// Two-stage synchroniser for the pad inputs
`timescale 1ns/1ns
module pcg_sync
  import pcg_pkg::*;
#(
  parameter int WIDTH = NUM_PINS
) (
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      stage1 <= '1;
      sync_o <= '1;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end

endmodule : pcg_sync

// file: hdl/pcg_decoder.sv
// Priority decoder: gives each enabled signal the lowest free pin
`timescale 1ns/1ns
module pcg_decoder
  import pcg_pkg::*;
(
  pcg_route_if.decoder rt
);

  logic [NUM_PINS-1:0] taken;

  always_comb begin
    taken           = rt.claim | rt.skip;
    rt.sig_ok       = '0;
    rt.sig_pin      = '0;
    rt.pin_assigned = '0;
    rt.pin_sig      = '0;
    for (int s = 0; s < NUM_SIG; s++) begin
      for (int p = 0; p < NUM_PINS; p++) begin
        if (rt.sig_en[s] && !rt.sig_ok[s] && !taken[p]) begin
          rt.sig_ok[s]       = 1'b1;
          rt.sig_pin[s]      = PIN_W'(p);
          taken[p]           = 1'b1;
          rt.pin_assigned[p] = 1'b1;
          rt.pin_sig[p]      = SIG_W'(s);
        end
      end
    end
  end

endmodule : pcg_decoder

// file: verif/pcg_top_asserts.sv
// Concurrent checks on the port crossbar block ports
`timescale 1ns/1ns
module pcg_top_asserts
  import pcg_pkg::*;
(
  input wire logic                clock_i,
  input wire logic                rst_i,
  input wire logic [7:0]          sfr_addr_i,
  input wire logic                sfr_wr_i,
  input wire logic [7:0]          sfr_wdata_i,
  input wire logic                sfr_bit_wr_i,
  input wire logic                sfr_rd_i,
  input wire logic                sfr_rmw_i,
  input wire logic [7:0]          sfr_rdata_o,
  input wire logic [NUM_PINS-1:0] pin_o,
  input wire logic [NUM_PINS-1:0] pin_oe_n_o,
  input wire logic [NUM_PINS-1:0] pullup_en_o,
  input wire logic [NUM_PINS-1:0] digital_rx_en_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // ------------
  // Sequences
  // ------------
  sequence s_wr(logic [7:0] a);
    sfr_wr_i && sfr_addr_i == a;
  endsequence
  sequence s_rd(logic [7:0] a, logic m);
    sfr_rd_i && sfr_rmw_i == m && !sfr_wr_i && !sfr_bit_wr_i && sfr_addr_i == a;
  endsequence

  // ------------
  // Assertions
  // ------------
  a_rmw_latch: assert property (s_wr(ADDR_PORT_A_LATCH) ##1 s_rd(ADDR_PORT_A_LATCH, 1'b1)
    |=> sfr_rdata_o == $past(sfr_wdata_i, 2)) else $error("latch read-back differs from last write");
  a_kind_follow: assert property (s_wr(ADDR_PORT_A_KIND)
    |=> ##1 digital_rx_en_o[7:0] == $past(sfr_wdata_i, 2)) else $error("receiver enable ignores kind write");
  a_off_quiet: assert property (s_wr(ADDR_ROUTE_SECOND) ##0 !sfr_wdata_i[POS_MATRIX_ENABLE]
    |=> ##1 pin_oe_n_o == '1) else $error("pin driven with matrix off");
  a_pull_off: assert property (s_wr(ADDR_ROUTE_SECOND) ##0 sfr_wdata_i[POS_PULLUP_DISABLE]
    |=> ##1 pullup_en_o == '0) else $error("pull-up on while disabled");
  a_analog_quiet: assert property ((~digital_rx_en_o & (pullup_en_o | ~pin_oe_n_o)) == '0)
    else $error("analog pin driven or pulled up");
  a_low_no_pull: assert property ((~pin_oe_n_o & ~pin_o & pullup_en_o) == '0)
    else $error("pull-up on while pin driven low");
  a_analog_zero: assert property (s_rd(ADDR_PORT_A_LATCH, 1'b0)
    |=> (sfr_rdata_o & ~digital_rx_en_o[7:0]) == 8'h00) else $error("analog pin reads one");
  a_third_spare: assert property (s_rd(ADDR_ROUTE_THIRD, 1'b0)
    |=> sfr_rdata_o[7:1] == 7'h00) else $error("reserved routing bits read non-zero");
  a_rst_quiet: assert property (disable iff (1'b0) rst_i |=> pin_oe_n_o == '1 && pullup_en_o == '1
    && sfr_rdata_o == 8'h00) else $error("outputs not at reset values");
endmodule : pcg_top_asserts

bind pcg_top pcg_top_asserts i_pcg_top_asserts (.clock_i, .rst_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i,
  .sfr_bit_wr_i, .sfr_rd_i, .sfr_rmw_i, .sfr_rdata_o, .pin_o, .pin_oe_n_o, .pullup_en_o, .digital_rx_en_o);

// file: verif/tb_top.sv
// Self-checking bench for the port crossbar and port A/B I/O block
`timescale 1ns/1ns
module tb_top;
  import pcg_pkg::*;

  // ------------
  // Signals
  // ------------
  logic                clock_i, rst_i, sfr_wr_i, sfr_bit_wr_i, sfr_bit_val_i, sfr_rd_i, sfr_rmw_i;
  logic                first_serial_enable_i;
  logic [2:0]          sfr_bit_sel_i;
  logic [7:0]          sfr_addr_i, sfr_wdata_i, sfr_rdata_o, v;
  logic [NUM_SIG-1:0]  periph_out_i, periph_oe_i, periph_in_o, periph_routed_o;
  logic [NUM_PINS-1:0] upstream_claim_i, twowire_pins_i, pin_i, pin_o, pin_oe_n_o, pullup_en_o, digital_rx_en_o;
  logic [NUM_PINS-1:0] r, c, lat, dm, kd, tw, fr;
  logic [31:0]         lfsr = 32'h0000_1352;
  int                  miscompares = 0;
  int                  check_count = 0;
  int                  p;
  localparam logic [7:0] ADDRS [9] = '{ADDR_PORT_A_LATCH, ADDR_PORT_B_LATCH, ADDR_PORT_A_DRIVE, ADDR_PORT_B_DRIVE,
    ADDR_PORT_A_SKIP, ADDR_ROUTE_SECOND, ADDR_ROUTE_THIRD, ADDR_PORT_A_KIND, ADDR_PORT_B_KIND};
  localparam logic [7:0] RSTV [9] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff};

  pcg_top i_pcg_top (.clock_i, .rst_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_bit_wr_i, .sfr_bit_sel_i,
    .sfr_bit_val_i, .sfr_rd_i, .sfr_rmw_i, .sfr_rdata_o, .upstream_claim_i, .first_serial_enable_i,
    .twowire_pins_i, .periph_out_i, .periph_oe_i, .periph_in_o, .periph_routed_o, .pin_i, .pin_o, .pin_oe_n_o,
    .pullup_en_o, .digital_rx_en_o);

  // ------------
  // Helpers
  // ------------
  function automatic logic [31:0] next_lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_lfsr
  function automatic logic [15:0] exp_oe_n(input logic [15:0] l, m, k, t);
    return ~(k & (~l | (m & ~t)));
  endfunction : exp_oe_n
  function automatic logic [15:0] exp_pull(input logic [15:0] l, m, k, t);
    return k & l & ~(m & ~t);
  endfunction : exp_pull
  function automatic logic [9:0] exp_routed(input logic [7:0] x, input logic s);
    logic [4:0] cm;
    cm = (x[2:0] > 3'h5) ? 5'h00 : 5'(5'h1f >> (3'h5 - x[2:0]));
    return x[6] ? {s, s, x[5:3], cm} : 10'h000;
  endfunction : exp_routed

  task automatic chk(input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic op(input logic w, b, rq, m, input logic [7:0] a, d, input logic [2:0] s = 3'h0);
    sfr_wr_i      <= w;
    sfr_bit_wr_i  <= b;
    sfr_rd_i      <= rq;
    sfr_rmw_i     <= m;
    sfr_addr_i    <= a;
    sfr_wdata_i   <= d;
    sfr_bit_sel_i <= s;
    sfr_bit_val_i <= d[0];
    @(posedge clock_i);
  endtask : op
  task automatic wr(input logic [7:0] a, d);
    op(1'b1, 1'b0, 1'b0, 1'b0, a, d);
  endtask : wr
  task automatic idle(input int n);
    repeat (n) op(1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
  endtask : idle
  task automatic rd(input logic [7:0] a, input logic m, output logic [7:0] q);
    op(1'b0, 1'b0, 1'b1, m, a, 8'h00);
    idle(1);
    q = sfr_rdata_o;
  endtask : rd
  task automatic rnd(output logic [15:0] q);
    repeat (5) lfsr = next_lfsr(lfsr);
    q = lfsr[15:0];
  endtask : rnd
  task automatic give_verdict();
    if (miscompares == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  always #5 clock_i = ~clock_i;

  initial begin
    repeat (50000) @(posedge clock_i);
    miscompares++;
    give_verdict();
  end

  initial begin
    clock_i = 1'b0;
    rst_i = 1'b1;
    {sfr_wr_i, sfr_bit_wr_i, sfr_bit_val_i, sfr_rd_i, sfr_rmw_i, first_serial_enable_i} = '0;
    {sfr_bit_sel_i, sfr_addr_i, sfr_wdata_i, periph_out_i, periph_oe_i} = '0;
    {upstream_claim_i, twowire_pins_i, pin_i} = '0;
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    chk(pin_oe_n_o, 16'hffff);
    chk(pullup_en_o, 16'hffff);
    foreach (ADDRS[i]) begin
      rd(ADDRS[i], i < 2, v);
      chk(v, RSTV[i]);
    end
    foreach (ADDRS[i]) begin
      rnd(r);
      wr(ADDRS[i], ADDRS[i] == ADDR_ROUTE_THIRD ? {7'h00, r[0]} : r[7:0]);
      rd(ADDRS[i], i < 2, v);
      chk(v, ADDRS[i] == ADDR_ROUTE_THIRD ? {7'h00, r[0]} : r[7:0]);
    end
    wr(8'h81, 8'h5a);
    rd(8'h81, 1'b0, v);
    chk(v, 8'h00);
    // Single-bit writes land only in the port latches
    rnd(lat);
    wr(ADDR_PORT_A_LATCH, lat[7:0]);
    wr(ADDR_PORT_B_LATCH, lat[15:8]);
    wr(ADDR_PORT_A_DRIVE, 8'h00);
    repeat (24) begin
      rnd(r);
      op(1'b0, 1'b1, 1'b0, 1'b0, r[8] ? ADDR_PORT_B_LATCH : ADDR_PORT_A_LATCH, {7'h00, r[0]}, r[3:1]);
      lat[{r[8], r[3:1]}] = r[0];
    end
    op(1'b0, 1'b1, 1'b0, 1'b0, ADDR_PORT_A_DRIVE, 8'h01, 3'h2);
    rd(ADDR_PORT_A_LATCH, 1'b1, v);
    chk(v, lat[7:0]);
    rd(ADDR_PORT_B_LATCH, 1'b1, v);
    chk(v, lat[15:8]);
    rd(ADDR_PORT_A_DRIVE, 1'b0, v);
    chk(v, 8'h00);
    // Pin drive, pull-ups and pin reads as GPIO
    wr(ADDR_PORT_A_SKIP, 8'h00);
    wr(ADDR_ROUTE_THIRD, 8'h00);
    wr(ADDR_ROUTE_SECOND, 8'h40);
    for (int k = 0; k < 8; k++) begin
      rnd(lat);
      rnd(dm);
      rnd(kd);
      rnd(tw);
      if (k == 0) begin
        kd = 16'hffff;
        tw = 16'h0000;
      end
      wr(ADDR_PORT_A_LATCH, lat[7:0]);
      wr(ADDR_PORT_B_LATCH, lat[15:8]);
      wr(ADDR_PORT_A_DRIVE, dm[7:0]);
      wr(ADDR_PORT_B_DRIVE, dm[15:8]);
      wr(ADDR_PORT_A_KIND, kd[7:0]);
      wr(ADDR_PORT_B_KIND, kd[15:8]);
      wr(ADDR_PORT_A_SKIP, ~kd[7:0]);
      rnd(r);
      twowire_pins_i <= tw;
      pin_i <= r;
      idle(4);
      fr = exp_oe_n(lat, dm, kd, tw);
      chk(pin_oe_n_o, fr);
      chk(pullup_en_o, exp_pull(lat, dm, kd, tw));
      chk(pin_o & ~pin_oe_n_o, lat & ~fr);
      chk(digital_rx_en_o, kd);
      rd(ADDR_PORT_A_LATCH, 1'b0, v);
      chk(v, r[7:0] & kd[7:0]);
      rd(ADDR_PORT_B_LATCH, 1'b0, v);
      chk(v, r[15:8] & kd[15:8]);
    end
    wr(ADDR_ROUTE_SECOND, 8'hc0);
    idle(3);
    chk(pullup_en_o, 16'h0000);
    wr(ADDR_ROUTE_SECOND, 8'h00);
    idle(3);
    chk(pin_oe_n_o, 16'hffff);
    // Every routing code, matrix on and off
    wr(ADDR_PORT_A_KIND, 8'hff);
    wr(ADDR_PORT_B_KIND, 8'hff);
    twowire_pins_i <= 16'h0000;
    for (int i = 0; i < 256; i++) begin
      wr(ADDR_ROUTE_SECOND, {1'b0, ~i[7], i[5:0]});
      wr(ADDR_ROUTE_THIRD, {7'h00, i[6]});
      idle(3);
      chk(periph_routed_o, exp_routed({1'b0, ~i[7], i[5:0]}, i[6]));
    end
    // Lowest free pin goes to the first compare output
    wr(ADDR_ROUTE_THIRD, 8'h00);
    wr(ADDR_PORT_A_DRIVE, 8'hff);
    wr(ADDR_PORT_B_DRIVE, 8'hff);
    repeat (12) begin
      rnd(r);
      rnd(c);
      rnd(tw);
      wr(ADDR_PORT_A_SKIP, r[7:0]);
      wr(ADDR_ROUTE_SECOND, 8'h41);
      upstream_claim_i <= c;
      first_serial_enable_i <= r[8];
      periph_out_i <= {NUM_SIG{r[9]}};
      periph_oe_i <= 10'h3ff;
      pin_i <= tw;
      idle(4);
      fr = ~(c | {8'h00, r[7:0]} | (r[8] ? FIRST_SERIAL_PINS : 16'h0000));
      p = 0;
      while (p < 15 && !fr[p]) p++;
      chk(periph_routed_o[0], |fr);
      if (|fr) chk({pin_oe_n_o[p], pin_o[p], periph_in_o[0]}, {1'b0, r[9], tw[p]});
    end
    give_verdict();
  end
endmodule : tb_top
